// [design/otp_cfg_pkg.sv]
// Constants for the standalone pattern and open-load response configuration bank.
// Assumes an internal register access port driven by the serial command decoder.
package otp_cfg_pkg;
    localparam logic [7:0] PATTERN_HI_ADDR = 8'h20;
    localparam logic [7:0] PATTERN_A_LOW_ADDR = 8'h21;
    localparam logic [7:0] PATTERN_B_LOW_ADDR = 8'h22;
    localparam logic [7:0] SETUP_ADDR = 8'h23;
    localparam logic [7:0] CMD_WRITE = 8'h20;
    localparam logic [7:0] CMD_READ = 8'h21;
    localparam logic [7:0] CMD_READ_ALT = 8'h28;
    localparam logic [7:0] PATTERN_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam int CHECK_EN_BIT = 7;
    localparam int RESPONSE_MSB = 6;
    localparam int RESPONSE_LSB = 5;
    localparam int ADDR_LOW_MSB = 4;
    localparam logic [1:0] ADDR_FIXED_HI = 2'h1;
    localparam logic [6:0] FRESH_ADDR = 7'h20;
    localparam logic [1:0] RESP_RECOVERY_UNDRIVEN = 2'h0;
    localparam logic [1:0] RESP_RECOVERY_DRIVEN = 2'h1;
    localparam logic [1:0] RESP_OUTAGE_UNDRIVEN = 2'h2;
    localparam logic [1:0] RESP_OUTAGE_DRIVEN = 2'h3;
endpackage

// [design/open_load_response.sv]
// Open-load response engine: decides channel enables and flag drive per response mode.
// Assumes synchronous fault, flag and power-good inputs from the analog front end.
`timescale 1ns/100ps
module open_load_response #(
    parameter int CHANNELS = 12
) (
    input wire logic clk,
    input wire logic rst,
    // Configuration, sampled at each evaluation
    input wire logic [1:0] response_mode,
    input wire logic [CHANNELS-1:0] base_enable,
    // Diagnosis and pins
    input wire logic power_good,
    input wire logic [CHANNELS-1:0] open_fault,
    input wire logic fault_flag_in,
    // Results
    output logic [CHANNELS-1:0] enable_reg,
    output logic [CHANNELS-1:0] force_reg,
    output logic flag_drive_reg,
    output logic low_power_reg
);
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_RECOVER = 3'b010,
        ST_SHUTDOWN = 3'b100
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [CHANNELS-1:0] enable_next;
    logic [CHANNELS-1:0] force_next;

    wire recovery = ~response_mode[1];
    wire driven = response_mode[0];
    wire any_fault = |open_fault;
    wire diag_valid = recovery ? power_good : 1'b1;
    wire fault_seen = diag_valid & any_fault;
    wire ext_flag = recovery & power_good & fault_flag_in;

    always_comb begin
        state_next = ST_NORMAL;
        enable_next = ~base_enable;
        force_next = '0;
        case (state_reg)
            ST_NORMAL, ST_RECOVER: begin
                if (ext_flag) begin
                    state_next = ST_SHUTDOWN;
                end else if (recovery && power_good && any_fault) begin
                    state_next = ST_RECOVER;
                end else begin
                    state_next = ST_NORMAL;
                end
            end
            ST_SHUTDOWN: begin
                state_next = (recovery && power_good) ? ST_SHUTDOWN : ST_NORMAL;
            end
            default: state_next = ST_NORMAL;
        endcase
        case (state_next)
            ST_RECOVER: begin
                enable_next = '0;
                force_next = open_fault;
            end
            ST_SHUTDOWN: enable_next = '0;
            default: enable_next = ~base_enable;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_NORMAL;
            enable_reg <= '0;
            force_reg <= '0;
            flag_drive_reg <= 1'b0;
            low_power_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            enable_reg <= enable_next;
            force_reg <= force_next;
            flag_drive_reg <= driven & fault_seen;
            low_power_reg <= (state_next == ST_SHUTDOWN);
        end
    end

    recover_force_a: assert property (@(posedge clk) disable iff (rst)
        (recovery && power_good && any_fault && !ext_flag && state_reg != ST_SHUTDOWN)
        |=> (force_reg == $past(open_fault)) && (enable_reg == '0))
        else $error("recovery did not force faulty channel");
    outage_keep_a: assert property (@(posedge clk) disable iff (rst)
        (!recovery && state_reg != ST_SHUTDOWN) |=> enable_reg == ~$past(base_enable))
        else $error("outage changed regulation");
    ext_flag_off_a: assert property (@(posedge clk) disable iff (rst)
        ext_flag |=> low_power_reg && enable_reg == '0)
        else $error("external flag did not shut outputs");
    no_pg_ignore_a: assert property (@(posedge clk) disable iff (rst)
        (recovery && !power_good) |=> !flag_drive_reg && force_reg == '0)
        else $error("diagnosis acted without power good");
    undriven_flag_a: assert property (@(posedge clk) disable iff (rst)
        !driven |=> !flag_drive_reg)
        else $error("flag driven in undriven mode");
endmodule

// [design/standalone_config.sv]
// Configuration bank for standalone patterns, bus check enable, response mode and address.
// Assumes the serial engine presents decoded commands as one-cycle strobes with a register address.
// Summary of operation
// - Pattern B low byte gives channels 7..0 when select pin is high; 0 on.
// - Pattern B low register sits at 0x22, reset 0x00.
// - Setup byte at 0x23, reset 0x00: check enable, response field, address bits.
// - Both registers read and write through commands 0x20, 0x21, 0x28.
// - Check enable bit 7 set to 1 turns on parity checking in bus driven operation.
// - Response field: recovery or outage, flag undriven or driven, per code.
// - Flag pin driven on open load only in a driven setting.
// - Recovery diagnosis runs only while power good is high.
// - Recovery fault forces current in faulty channel, others off.
// - Recovery resumes normal channels once the fault clears.
// - Recovery: external flag turns all outputs off, enters low power.
// - Recovery without power good ignores flag input and diagnosis.
// - Outage diagnoses but never alters current regulation.
// - Outage ignores an externally asserted flag.
// - Slave address is 01 followed by five programmed low bits.
// - Select pin low takes twelve enables from pattern A.
// - Pattern B bits 11..8 sit in upper nibble of 0x20, same encoding.
// - Unprogrammed device answers slave address 0100000.
`timescale 1ns/100ps
module standalone_config #(
    parameter int CHANNELS = 12
) (
    input wire logic clk,
    input wire logic rst,
    // Command port from the serial engine
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic [7:0] cmd_rdata_reg,
    output logic cmd_rvalid_reg,
    // Bus transaction framing and programming state
    input wire logic bus_busy,
    input wire logic address_programmed,
    output logic [6:0] slave_address_reg,
    output logic bus_error_check_enable_reg,
    // Mode and pins
    input wire logic bus_driven_operation,
    input wire logic pattern_select_pin,
    input wire logic power_good,
    input wire logic [CHANNELS-1:0] open_fault,
    input wire logic fault_flag_in,
    output logic fault_flag_out_reg,
    output logic fault_flag_oe_reg,
    output logic [CHANNELS-1:0] channel_enable_vector,
    output logic [CHANNELS-1:0] channel_force,
    output logic low_power
);
    logic [7:0] pattern_hi_reg;
    logic [7:0] pattern_a_low_reg;
    logic [7:0] pattern_b_low_reg;
    logic [7:0] setup_reg;
    logic [1:0] response_reg;
    logic [CHANNELS-1:0] en_int;
    logic [CHANNELS-1:0] force_int;
    logic drive_int;
    logic lp_int;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    wire is_write = cmd_valid & hit(cmd_code, otp_cfg_pkg::CMD_WRITE);
    wire is_read = cmd_valid & (hit(cmd_code, otp_cfg_pkg::CMD_READ) |
        hit(cmd_code, otp_cfg_pkg::CMD_READ_ALT));
    wire wr_hi = is_write & hit(cmd_addr, otp_cfg_pkg::PATTERN_HI_ADDR);
    wire wr_a = is_write & hit(cmd_addr, otp_cfg_pkg::PATTERN_A_LOW_ADDR);
    wire wr_b = is_write & hit(cmd_addr, otp_cfg_pkg::PATTERN_B_LOW_ADDR);
    wire wr_setup = is_write & hit(cmd_addr, otp_cfg_pkg::SETUP_ADDR);
    wire [7:0] rd_mux =
        hit(cmd_addr, otp_cfg_pkg::PATTERN_HI_ADDR) ? pattern_hi_reg :
        hit(cmd_addr, otp_cfg_pkg::PATTERN_A_LOW_ADDR) ? pattern_a_low_reg :
        hit(cmd_addr, otp_cfg_pkg::PATTERN_B_LOW_ADDR) ? pattern_b_low_reg :
        hit(cmd_addr, otp_cfg_pkg::SETUP_ADDR) ? setup_reg : 8'h00;
    // Pattern B high nibble lives in the shared register alongside pattern A
    wire [CHANNELS-1:0] pattern_a = {pattern_hi_reg[3:0], pattern_a_low_reg};
    wire [CHANNELS-1:0] pattern_b = {pattern_hi_reg[7:4], pattern_b_low_reg};
    // Bus mode patterns are supplied elsewhere; here all channels are allowed
    wire [CHANNELS-1:0] base_off = bus_driven_operation ? '0 :
        (pattern_select_pin ? pattern_b : pattern_a);
    wire [6:0] addr_next = address_programmed ?
        {otp_cfg_pkg::ADDR_FIXED_HI, setup_reg[otp_cfg_pkg::ADDR_LOW_MSB:0]} :
        otp_cfg_pkg::FRESH_ADDR;

    always_ff @(posedge clk) begin
        if (rst) begin
            pattern_hi_reg <= otp_cfg_pkg::PATTERN_RESET;
            pattern_a_low_reg <= otp_cfg_pkg::PATTERN_RESET;
            pattern_b_low_reg <= otp_cfg_pkg::PATTERN_RESET;
            setup_reg <= otp_cfg_pkg::SETUP_RESET;
        end else begin
            if (wr_hi) pattern_hi_reg <= cmd_wdata;
            if (wr_a) pattern_a_low_reg <= cmd_wdata;
            if (wr_b) pattern_b_low_reg <= cmd_wdata;
            if (wr_setup) setup_reg <= cmd_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_rdata_reg <= 8'h00;
            cmd_rvalid_reg <= 1'b0;
        end else begin
            cmd_rvalid_reg <= is_read;
            if (is_read) cmd_rdata_reg <= rd_mux;
        end
    end

    // Bus-facing fields only move between transactions
    always_ff @(posedge clk) begin
        if (rst) begin
            slave_address_reg <= otp_cfg_pkg::FRESH_ADDR;
            bus_error_check_enable_reg <= 1'b0;
        end else if (!bus_busy) begin
            slave_address_reg <= addr_next;
            bus_error_check_enable_reg <= setup_reg[otp_cfg_pkg::CHECK_EN_BIT];
        end
    end

    // Response mode is resampled every cycle, i.e. at each diagnosis evaluation
    always_ff @(posedge clk) begin
        if (rst) response_reg <= otp_cfg_pkg::RESP_RECOVERY_UNDRIVEN;
        else response_reg <= setup_reg[otp_cfg_pkg::RESPONSE_MSB:otp_cfg_pkg::RESPONSE_LSB];
    end

    open_load_response #(
        .CHANNELS(CHANNELS)
    ) u_resp (
        .clk(clk),
        .rst(rst),
        .response_mode(response_reg),
        .base_enable(base_off),
        .power_good(power_good),
        .open_fault(open_fault),
        .fault_flag_in(fault_flag_in),
        .enable_reg(en_int),
        .force_reg(force_int),
        .flag_drive_reg(drive_int),
        .low_power_reg(lp_int)
    );

    // Open-drain flag: pull low while driving
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_flag_out_reg <= 1'b0;
            fault_flag_oe_reg <= 1'b0;
        end else begin
            fault_flag_out_reg <= 1'b0;
            fault_flag_oe_reg <= drive_int;
        end
    end

    assign channel_enable_vector = en_int;
    assign channel_force = force_int;
    assign low_power = lp_int;

    reg_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_b |=> pattern_b_low_reg == $past(cmd_wdata))
        else $error("pattern b write lost");
    read_back_a: assert property (@(posedge clk) disable iff (rst)
        (is_read && hit(cmd_addr, otp_cfg_pkg::SETUP_ADDR)) |=> cmd_rvalid_reg && cmd_rdata_reg == $past(setup_reg))
        else $error("setup read mismatch");
    addr_form_a: assert property (@(posedge clk) disable iff (rst)
        (!bus_busy && address_programmed) |=> slave_address_reg[6:5] == 2'h1 &&
        slave_address_reg[4:0] == $past(setup_reg[4:0]))
        else $error("slave address mis-formed");
    fresh_addr_a: assert property (@(posedge clk) disable iff (rst)
        (!bus_busy && !address_programmed) |=> slave_address_reg == 7'h20)
        else $error("fresh address wrong");
    busy_hold_a: assert property (@(posedge clk) disable iff (rst)
        bus_busy |=> $stable(slave_address_reg) && $stable(bus_error_check_enable_reg))
        else $error("bus field changed mid transaction");
    check_en_a: assert property (@(posedge clk) disable iff (rst)
        !bus_busy |=> bus_error_check_enable_reg == $past(setup_reg[7]))
        else $error("check enable not applied");
endmodule

// [dv/cmd_master.sv]
// Command master model standing in for the serial engine that decodes host traffic.
// Assumes the bench clock; it changes requests only just after a rising edge.
`timescale 1ns/100ps
module cmd_master (
    // Clock
    input wire logic clk,
    // Command strobe and fields
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_addr,
    output logic [7:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_addr = 8'h00;
        cmd_wdata = 8'h00;
    end

    // One-cycle strobe; fields are inverted afterwards so nothing leans on stale values
    task automatic send(input logic [7:0] code, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_addr <= addr;
        cmd_wdata <= data;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_addr <= ~addr;
        cmd_wdata <= ~data;
    endtask
endmodule

// [dv/test_standalone_config.sv]
// Self-checking bench for the configuration bank and open-load response.
// Assumes the command master model drives the command port.
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_standalone_config;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic bus_busy = 1'b0;
    logic address_programmed = 1'b0;
    logic bus_driven_operation = 1'b0;
    logic pattern_select_pin = 1'b0;
    logic power_good = 1'b0;
    logic fault_flag_in = 1'b0;
    logic [11:0] open_fault = 12'h000;
    logic cmd_valid, cmd_rvalid_reg, bus_error_check_enable_reg, fault_flag_out_reg, fault_flag_oe_reg, low_power;
    logic [7:0] cmd_code, cmd_addr, cmd_wdata, cmd_rdata_reg, v, a;
    logic [6:0] slave_address_reg;
    logic [11:0] channel_enable_vector, channel_force;
    logic [7:0] mdl[int];
    int err_count = 0;
    int checks = 0;

    always #2 clk = ~clk;

    cmd_master i_cmd_master (.clk, .cmd_valid, .cmd_code, .cmd_addr, .cmd_wdata);
    standalone_config #(.CHANNELS(12)) i_standalone_config (.clk, .rst, .cmd_valid, .cmd_code, .cmd_addr,
        .cmd_wdata, .cmd_rdata_reg, .cmd_rvalid_reg, .bus_busy, .address_programmed, .slave_address_reg,
        .bus_error_check_enable_reg, .bus_driven_operation, .pattern_select_pin, .power_good, .open_fault,
        .fault_flag_in, .fault_flag_out_reg, .fault_flag_oe_reg, .channel_enable_vector, .channel_force, .low_power);

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_cmd_master.send(8'h20, addr, data);
        mdl[addr] = data;
    endtask

    task automatic rd(input logic [7:0] code, input logic [7:0] addr, output logic [7:0] d);
        int n;
        n = 0;
        i_cmd_master.send(code, addr, 8'h5a);
        #1;
        while (cmd_rvalid_reg !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 4) begin
            err_count++;
            stop_test();
        end else begin
            d = cmd_rdata_reg;
            @(posedge clk);
            #1;
            `CHK(cmd_rvalid_reg, 1'b0)
        end
    endtask

    task automatic set_pins(input logic pg, input logic fi, input logic [11:0] of);
        @(posedge clk);
        power_good <= pg;
        fault_flag_in <= fi;
        open_fault <= of;
        settle();
    endtask

    initial begin
        #200000;
        err_count++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h7f506379));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int k = 8'h20; k <= 8'h23; k++) mdl[k] = 8'h00;
        rd(8'h21, 8'h22, v); `CHK(v, 8'h00)
        rd(8'h28, 8'h23, v); `CHK(v, 8'h00)
        `CHK(slave_address_reg, 7'h20)
        for (int i = 0; i < 8; i++) begin
            a = 8'h20 + 8'(i[1:0]);
            wr(a, 8'($urandom()));
            rd(i[2] ? 8'h28 : 8'h21, a, v); `CHK(v, mdl[a])
        end
        // Unknown code must leave the bank untouched; an unknown address reads back 0x00
        i_cmd_master.send(8'h55, 8'h22, ~mdl[8'h22]);
        rd(8'h21, 8'h22, v); `CHK(v, mdl[8'h22])
        rd(8'h21, 8'h30, v); `CHK(v, 8'h00)
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            pattern_select_pin <= s[0];
            settle();
            `CHK(channel_enable_vector, s ? ~{mdl[8'h20][7:4], mdl[8'h22]} : ~{mdl[8'h20][3:0], mdl[8'h21]})
        end
        v = 8'($urandom());
        @(posedge clk);
        address_programmed <= 1'b1;
        wr(8'h23, {3'b100, v[4:0]});
        settle();
        `CHK(slave_address_reg, {2'b01, v[4:0]})
        `CHK(bus_error_check_enable_reg, 1'b1)
        // A transaction in flight keeps the old address; the check setting is checked only after it ends
        @(posedge clk);
        bus_busy <= 1'b1;
        wr(8'h23, {3'b001, ~v[4:0]});
        settle();
        `CHK(slave_address_reg, {2'b01, v[4:0]})
        @(posedge clk);
        bus_busy <= 1'b0;
        settle();
        `CHK(slave_address_reg, {2'b01, ~v[4:0]})
        `CHK(bus_error_check_enable_reg, 1'b0)
        wr(8'h20, 8'h00);
        wr(8'h22, 8'h00);
        set_pins(1'b0, 1'b1, 12'h008);
        `CHK({channel_enable_vector, fault_flag_oe_reg, low_power}, {12'hfff, 2'b00})
        set_pins(1'b1, 1'b0, 12'h008);
        `CHK({channel_enable_vector, channel_force, fault_flag_oe_reg}, {12'h000, 12'h008, 1'b1})
        `CHK(fault_flag_out_reg, 1'b0)
        set_pins(1'b1, 1'b0, 12'h000);
        `CHK({channel_enable_vector, channel_force}, {12'hfff, 12'h000})
        set_pins(1'b1, 1'b1, 12'h000);
        `CHK({channel_enable_vector, low_power}, {12'h000, 1'b1})
        set_pins(1'b0, 1'b0, 12'h000);
        wr(8'h23, {3'b000, ~v[4:0]});
        set_pins(1'b1, 1'b0, 12'h008);
        `CHK(fault_flag_oe_reg, 1'b0)
        for (int m = 2; m < 4; m++) begin
            wr(8'h23, {1'b0, 2'(m), v[4:0]});
            set_pins(1'b1, 1'b1, 12'h008);
            `CHK({channel_enable_vector, channel_force, low_power}, {12'hfff, 12'h000, 1'b0})
            `CHK(fault_flag_oe_reg, m[0])
        end
        stop_test();
    end
endmodule
